// ===== rtl/tcs_trap_ctrl.sv
// Trap enable and status register with trap request generation.
//
// Contract
// - Bits 10 and 9 enable overflow traps of accumulator A and B.
// - Bit 8 enables traps on catastrophic overflow of either accumulator.
// - Bit 6 is set only by a math trap caused by divide by zero.
// - Bit 3 is set when an address error trap occurs, else clear; the code holds it set until software writes it to zero.
// - Bit 12 records a catastrophic overflow trap of accumulator A.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "tcs_defines.svh"
module tcs_trap_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`TCS_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`TCS_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tcs_pkg::tcs_events_s events,
  output tcs_pkg::tcs_traps_s traps,
  output logic nest_disable
);
  logic [`TCS_REG_W-1:0] trap_control_status_reg;
  logic [`TCS_REG_W-1:0] trap_control_status_next;
  logic [`TCS_REG_W-1:0] set_vec;
  logic [`TCS_REG_W-1:0] merged;
  logic wr_en;
  logic [`TCS_REG_W-1:0] wr_data;
  logic [1:0] wr_strb;
  logic ovf_a_hit;
  logic ovf_b_hit;
  logic cat_a_hit;
  logic cat_b_hit;
  logic math_any;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end.
  tcs_axil_slave u_bus (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_data(trap_control_status_reg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Enable gating of the accumulator overflow causes.
  assign ovf_a_hit = events.acc_a_ovf && trap_control_status_reg[`TCS_B_OVF_A_EN];
  assign ovf_b_hit = events.acc_b_ovf && trap_control_status_reg[`TCS_B_OVF_B_EN];
  assign cat_a_hit = events.acc_a_cat && trap_control_status_reg[`TCS_B_CAT_EN];
  assign cat_b_hit = events.acc_b_cat && trap_control_status_reg[`TCS_B_CAT_EN];
  assign math_any = ovf_a_hit || ovf_b_hit || cat_a_hit || cat_b_hit
                    || events.shift_err || events.div_zero;

  // Flags raised by this cycle's events.
  always_comb
  begin
    set_vec = '0;
    set_vec[`TCS_B_OVF_A_FLAG] = ovf_a_hit;
    set_vec[`TCS_B_OVF_B_FLAG] = ovf_b_hit;
    set_vec[`TCS_B_CAT_A_FLAG] = cat_a_hit;
    set_vec[`TCS_B_CAT_B_FLAG] = cat_b_hit;
    set_vec[`TCS_B_SHIFT_FLAG] = events.shift_err;
    set_vec[`TCS_B_DIVZ_FLAG] = events.div_zero;
    set_vec[`TCS_B_MATH_FLAG] = math_any;
    set_vec[`TCS_B_ADDR_FLAG] = events.addr_err;
    set_vec[`TCS_B_STACK_FLAG] = events.stack_err;
    set_vec[`TCS_B_OSC_FLAG] = events.osc_fail;
  end

  // Byte-lane merge of the write data over the present value.
  always_comb
  begin
    merged = trap_control_status_reg;
    if (wr_strb[0])
    begin
      merged[7:0] = wr_data[7:0];
    end
    if (wr_strb[1])
    begin
      merged[15:8] = wr_data[15:8];
    end
  end

  // Plain bits take the write, flags only clear on zero, and a set wins.
  always_comb
  begin
    trap_control_status_next = trap_control_status_reg;
    if (wr_en)
    begin
      trap_control_status_next = (merged & `TCS_PLAIN_MASK)
                                 | (trap_control_status_reg & merged & `TCS_FLAG_MASK);
    end
    trap_control_status_next = trap_control_status_next | set_vec;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and status register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trap_control_status_reg <= `TCS_RESET_VAL;
    end
    else if (ce)
    begin
      trap_control_status_reg <= trap_control_status_next;
    end
  end

  // Trap requests, one cycle after their cause.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      traps <= '0;
    end
    else if (ce)
    begin
      traps.math_trap <= math_any;
      traps.address_trap <= events.addr_err;
      traps.stack_trap <= events.stack_err;
      traps.osc_trap <= events.osc_fail;
    end
  end

  // Nesting disable is a plain control bit.
  assign nest_disable = trap_control_status_reg[`TCS_B_NEST];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Software write that clears the address fault flag.
  sequence s_clear_addr;
    ce && wr_en && wr_strb[0] && !wr_data[`TCS_B_ADDR_FLAG];
  endsequence
  // Address fault raised and seen on both flag and trap.
  sequence s_addr_seen;
    trap_control_status_reg[`TCS_B_ADDR_FLAG] && traps.address_trap;
  endsequence

  property p_ovf_a_trap;
    ce && events.acc_a_ovf && trap_control_status_reg[`TCS_B_OVF_A_EN]
      |=> traps.math_trap && trap_control_status_reg[`TCS_B_OVF_A_FLAG];
  endproperty
  a_ovf_a_trap: assert property (p_ovf_a_trap)
    else $error("Enabled accumulator A overflow gave no trap.");

  property p_ovf_b_masked;
    ce && events.acc_b_ovf && !trap_control_status_reg[`TCS_B_OVF_B_EN]
      && !trap_control_status_reg[`TCS_B_OVF_B_FLAG]
      |=> !trap_control_status_reg[`TCS_B_OVF_B_FLAG];
  endproperty
  a_ovf_b_masked: assert property (p_ovf_b_masked)
    else $error("Disabled accumulator B overflow raised its flag.");

  property p_cat_trap;
    ce && (events.acc_a_cat || events.acc_b_cat) && trap_control_status_reg[`TCS_B_CAT_EN]
      |=> traps.math_trap;
  endproperty
  a_cat_trap: assert property (p_cat_trap)
    else $error("Enabled catastrophic overflow gave no trap.");

  property p_cat_masked;
    ce && !trap_control_status_reg[`TCS_B_CAT_EN] && !trap_control_status_reg[`TCS_B_CAT_A_FLAG]
      |=> !trap_control_status_reg[`TCS_B_CAT_A_FLAG];
  endproperty
  a_cat_masked: assert property (p_cat_masked)
    else $error("Catastrophic flag rose while its trap was disabled.");

  property p_divz_set;
    ce && events.div_zero
      |=> trap_control_status_reg[`TCS_B_DIVZ_FLAG] && trap_control_status_reg[`TCS_B_MATH_FLAG]
          && traps.math_trap;
  endproperty
  a_divz_set: assert property (p_divz_set)
    else $error("Divide by zero did not set its status.");

  property p_divz_only;
    ce && !events.div_zero && !trap_control_status_reg[`TCS_B_DIVZ_FLAG]
      |=> !trap_control_status_reg[`TCS_B_DIVZ_FLAG];
  endproperty
  a_divz_only: assert property (p_divz_only)
    else $error("Divide by zero flag rose without a divide by zero.");

  property p_addr_set;
    ce && events.addr_err |=> s_addr_seen;
  endproperty
  a_addr_set: assert property (p_addr_set)
    else $error("Address error did not set flag and trap.");

  property p_cat_a_flag;
    ce && events.acc_a_cat && trap_control_status_reg[`TCS_B_CAT_EN]
      |=> trap_control_status_reg[`TCS_B_CAT_A_FLAG];
  endproperty
  a_cat_a_flag: assert property (p_cat_a_flag)
    else $error("Accumulator A catastrophic flag not recorded.");

  property p_addr_sticky;
    ce && trap_control_status_reg[`TCS_B_ADDR_FLAG] && !(wr_en && wr_strb[0])
      |=> trap_control_status_reg[`TCS_B_ADDR_FLAG];
  endproperty
  a_addr_sticky: assert property (p_addr_sticky)
    else $error("Address fault flag dropped without a write.");

  property p_addr_clear;
    s_clear_addr and !events.addr_err |=> !trap_control_status_reg[`TCS_B_ADDR_FLAG];
  endproperty
  a_addr_clear: assert property (p_addr_clear)
    else $error("Writing zero did not clear the address fault flag.");

  property p_set_wins;
    s_clear_addr and events.addr_err |=> trap_control_status_reg[`TCS_B_ADDR_FLAG];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Address fault lost against a clearing write.");

  property p_freeze;
    !ce |=> $stable(trap_control_status_reg) && $stable(traps);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("State changed while clock enable was low.");
endmodule : tcs_trap_ctrl

// ===== rtl/tcs_defines.svh
// Register offsets, bit positions, masks and bus codes of the trap control block.
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH
`define TCS_AXI_AW 8
`define TCS_OFF_CTRL 8'h00
`define TCS_REG_W 16
`define TCS_RESET_VAL 16'h0000
`define TCS_B_NEST 15
`define TCS_B_OVF_A_FLAG 14
`define TCS_B_OVF_B_FLAG 13
`define TCS_B_CAT_A_FLAG 12
`define TCS_B_CAT_B_FLAG 11
`define TCS_B_OVF_A_EN 10
`define TCS_B_OVF_B_EN 9
`define TCS_B_CAT_EN 8
`define TCS_B_SHIFT_FLAG 7
`define TCS_B_DIVZ_FLAG 6
`define TCS_B_MATH_FLAG 4
`define TCS_B_ADDR_FLAG 3
`define TCS_B_STACK_FLAG 2
`define TCS_B_OSC_FLAG 1
`define TCS_PLAIN_MASK 16'h8700
`define TCS_FLAG_MASK 16'h78de
`define TCS_RESP_OKAY 2'h0
`define TCS_RESP_SLVERR 2'h2
`endif

// ===== rtl/tcs_pkg.sv
// Types and shared decode for the trap control block.
`include "tcs_defines.svh"
package tcs_pkg;
  // Error conditions raised by the core, each a one-cycle pulse.
  typedef struct packed {
    logic acc_a_ovf;
    logic acc_b_ovf;
    logic acc_a_cat;
    logic acc_b_cat;
    logic shift_err;
    logic div_zero;
    logic addr_err;
    logic stack_err;
    logic osc_fail;
  } tcs_events_s;
  // Trap requests handed to the dispatch logic.
  typedef struct packed {
    logic math_trap;
    logic address_trap;
    logic stack_trap;
    logic osc_trap;
  } tcs_traps_s;
  typedef enum logic [0:0] {TCS_WS_COLLECT = 1'h0, TCS_WS_RESP = 1'h1} tcs_wstate_e;
  typedef enum logic [0:0] {TCS_RS_IDLE = 1'h0, TCS_RS_DATA = 1'h1} tcs_rstate_e;
  // True when the byte address hits the control and status register.
  function automatic logic tcs_is_mapped(input logic [`TCS_AXI_AW-1:0] a);
    tcs_is_mapped = (a == `TCS_OFF_CTRL);
  endfunction : tcs_is_mapped
endpackage : tcs_pkg

// ===== rtl/tcs_axil_slave.sv
// AXI4-Lite slave front end of the trap control block.
`timescale 1ns/1ps
`include "tcs_defines.svh"
module tcs_axil_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`TCS_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`TCS_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [`TCS_REG_W-1:0] wr_data,
  output logic [1:0] wr_strb,
  input wire logic [`TCS_REG_W-1:0] rd_data
);
  tcs_pkg::tcs_wstate_e ws_reg;
  tcs_pkg::tcs_rstate_e rs_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [`TCS_AXI_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_go;

  // A write completes once address and data are both held.
  assign wr_go = ce && (ws_reg == tcs_pkg::TCS_WS_COLLECT) && aw_held_reg && w_held_reg;
  assign wr_en = wr_go && tcs_pkg::tcs_is_mapped(awaddr_reg);
  assign wr_data = wdata_reg[`TCS_REG_W-1:0];
  assign wr_strb = wstrb_reg[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Write channels: address and data taken in either order.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ws_reg <= tcs_pkg::TCS_WS_COLLECT;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCS_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      case (ws_reg)
        tcs_pkg::TCS_WS_COLLECT:
        begin
          if (wr_go)
          begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= tcs_pkg::tcs_is_mapped(awaddr_reg) ? `TCS_RESP_OKAY
                                                              : `TCS_RESP_SLVERR;
            ws_reg <= tcs_pkg::TCS_WS_RESP;
          end
        end
        tcs_pkg::TCS_WS_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            ws_reg <= tcs_pkg::TCS_WS_COLLECT;
          end
        end
        default: ws_reg <= tcs_pkg::TCS_WS_COLLECT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: data captured at the address handshake.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rs_reg <= tcs_pkg::TCS_RS_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `TCS_RESP_OKAY;
    end
    else if (ce)
    begin
      case (rs_reg)
        tcs_pkg::TCS_RS_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            if (tcs_pkg::tcs_is_mapped(s_axi_araddr))
            begin
              s_axi_rdata <= {16'h0000, rd_data};
              s_axi_rresp <= `TCS_RESP_OKAY;
            end
            else
            begin
              s_axi_rdata <= '0;
              s_axi_rresp <= `TCS_RESP_SLVERR;
            end
            rs_reg <= tcs_pkg::TCS_RS_DATA;
          end
        end
        tcs_pkg::TCS_RS_DATA:
        begin
          if (s_axi_rready)
          begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            rs_reg <= tcs_pkg::TCS_RS_IDLE;
          end
        end
        default: rs_reg <= tcs_pkg::TCS_RS_IDLE;
      endcase
    end
  end
endmodule : tcs_axil_slave

// ===== verification/tcs_core_model.sv
// Behavioural model of the core's arithmetic, address, stack and oscillator error sources.
`timescale 1ns/1ps
module tcs_core_model (
  input wire logic clk,
  output tcs_pkg::tcs_events_s events
);
  ////////////////////////////////////////////////////////////////////////////
  // Raise a set of error conditions for exactly one clock, then go idle.
  task automatic pulse(input logic [8:0] m);
    @(posedge clk);
    events <= m;
    @(posedge clk);
    events <= 9'h000;
  endtask : pulse

  // The core starts with no error condition pending.
  initial events = 9'h000;
endmodule : tcs_core_model

// ===== verification/tb_top.sv
// Self-checking bench for the trap control and status block.
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, ce;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, nest_disable;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  tcs_pkg::tcs_events_s events;
  tcs_pkg::tcs_traps_s traps;
  int failures, cmp_count;

  ////////////////////////////////////////////////////////////////////////////
  // Design and core model.
  tcs_trap_ctrl i_dut (
    .clk(clk), .rst(rst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .events(events),
    .traps(traps), .nest_disable(nest_disable)
  );
  tcs_core_model i_core (.clk(clk), .events(events));

  // 50 MHz clock.
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Print the counts and the verdict, then end the run.
  task automatic stop_test;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // Compare one value and report a mismatch.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // A wait that runs out of cycles ends the run as a failure.
  task automatic timeout(input int n);
    if (n == 50)
    begin
      failures++;
      $display("unexpected bus wait expected answer seen none");
      stop_test();
    end
  endtask : timeout

  // Single AXI4-Lite write; each channel is released once it is taken.
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= {16'h0000, d};
    wstrb <= 4'hf;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    timeout(n);
    bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  // Single AXI4-Lite read with expected response and data.
  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [15:0] ed);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    timeout(n);
    rready <= 1'h0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("rdata", {16'h0000, ed}, rdata);
  endtask : rd

  // One-cycle error event; the trap pulse lasts one cycle after it.
  task automatic ev(input logic [8:0] m, input logic [3:0] t);
    i_core.pulse(m);
    #1 chk("traps", {28'h0, t}, {28'h0, traps});
    @(posedge clk);
    #1 chk("traps idle", 32'h0, {28'h0, traps});
  endtask : ev

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    rst = 1'h1;
    ce = 1'h1;
    awaddr = 8'h00;
    araddr = 8'h00;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    failures = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    rd(8'h00, 2'h0, 16'h0000);
    wr(8'h00, 16'h8700, 2'h0);
    rd(8'h00, 2'h0, 16'h8700);
    chk("nest_disable", 32'h1, {31'h0, nest_disable});
    ev(9'h100, 4'h8);
    rd(8'h00, 2'h0, 16'hc710);
    ev(9'h040, 4'h8);
    rd(8'h00, 2'h0, 16'hd710);
    // Catastrophic overflow of accumulator B traps under the same enable.
    ev(9'h020, 4'h8);
    rd(8'h00, 2'h0, 16'hdf10);
    ev(9'h008, 4'h8);
    rd(8'h00, 2'h0, 16'hdf50);
    wr(8'h00, 16'h0000, 2'h0);
    ev(9'h010, 4'h8);
    rd(8'h00, 2'h0, 16'h0090);
    ev(9'h1e0, 4'h0);
    rd(8'h00, 2'h0, 16'h0090);
    wr(8'h00, 16'h0200, 2'h0);
    ev(9'h080, 4'h8);
    rd(8'h00, 2'h0, 16'h2210);
    ev(9'h004, 4'h4);
    rd(8'h00, 2'h0, 16'h2218);
    wr(8'h00, 16'h0008, 2'h0);
    rd(8'h00, 2'h0, 16'h0008);
    // Frozen clock enable: the event is not taken.
    @(posedge clk);
    ce <= 1'h0;
    ev(9'h002, 4'h0);
    @(posedge clk);
    ce <= 1'h1;
    ev(9'h002, 4'h2);
    ev(9'h001, 4'h1);
    rd(8'h00, 2'h0, 16'h000e);
    wr(8'h04, 16'hffff, 2'h2);
    rd(8'h04, 2'h2, 16'h0000);
    rd(8'h00, 2'h0, 16'h000e);
    // A clearing write lands on the edge of an address error; the set must win.
    fork
      wr(8'h00, 16'h0000, 2'h0);
      begin
        @(posedge clk);
        i_core.pulse(9'h004);
      end
    join
    rd(8'h00, 2'h0, 16'h0008);
    // Reset in mid-run clears every bit and reopens the bus.
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    chk("bus idle", 32'h1c, {27'h0, awready, wready, arready, bvalid, rvalid});
    chk("nest_disable", 32'h0, {31'h0, nest_disable});
    rd(8'h00, 2'h0, 16'h0000);
    stop_test();
  end
endmodule : tb_top
